// ---- inc/acl_consts.svh ----
/*
 * Constants of the calibration and mode control block: register offsets,
 * instruction field positions, command codes, acquisition selections and sizes.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef ACL_CONSTS_SVH
`define ACL_CONSTS_SVH

// Register offsets on the plain register port (byte addresses).
`define ACL_OFS_CTRL 4'h0
`define ACL_OFS_STATUS 4'h4
`define ACL_OFS_MODE 4'h8
`define ACL_OFS_RESULT 4'hC

// Control register bits, write-one pulses.
`define ACL_CTRL_CAL_BIT 0
`define ACL_CTRL_ZERO_BIT 1

// Instruction layout: low nibble all ones marks a command word.
`define ACL_INSTR_W 8
`define ACL_CMD_MARK 4'hF
`define ACL_CMD_CAL 4'h0
`define ACL_CMD_ZERO 4'h1
`define ACL_CMD_PWR_UP 4'h2
`define ACL_CMD_PWR_DOWN 4'h3
`define ACL_CMD_ACQ6 4'h4
`define ACL_CMD_ACQ10 4'h5
`define ACL_CMD_ACQ18 4'h6
`define ACL_CMD_ACQ34 4'h7
`define ACL_CMD_SIGN_ON 4'h8
`define ACL_CMD_SIGN_OFF 4'h9
`define ACL_CMD_AZ_ON 4'hA
`define ACL_CMD_AZ_OFF 4'hB

// Conversion instruction fields.
`define ACL_F_CHAN_LSB 0
`define ACL_F_RES8 3
`define ACL_F_LSBF 4
`define ACL_F_EXT 5

// Acquisition selections, in conversion clock periods 6, 10, 18, 34.
`define ACL_ACQ_6 2'h0
`define ACL_ACQ_10 2'h1
`define ACL_ACQ_18 2'h2
`define ACL_ACQ_34 2'h3

// Output word sizes.
`define ACL_OUT_W 17
`define ACL_LEN_W 5
`define ACL_BASE_8 5'h08
`define ACL_BASE_12 5'h0C
`define ACL_BASE_16 5'h10

// Correction memory: entry 0 offset, entry 1 gain, entries 2..15 linearity.
`define ACL_COR_N 16
`define ACL_COR_IDX_W 4
`define ACL_COR_W 13
`define ACL_COR_OFS 4'h0
`define ACL_COR_GAIN 4'h1
`define ACL_COR_LIN0 4'h2
`define ACL_COR_LAST 4'hF
`define ACL_GAIN_SHIFT 12

`endif

// ---- inc/acl_pkg.sv ----
/*
 * Types of the calibration and mode control block.
 * Assumes acl_consts.svh is on the include path.
 */
`default_nettype none
`include "acl_consts.svh"

package acl_pkg;

   // Stored mode state, kept across frames.
   typedef struct packed {
      logic [2:0] chan;
      logic res8;
      logic lsb_first;
      logic ext_len;
      logic sign_on;
      logic [1:0] acq_sel;
      logic power_down;
      logic auto_zero;
   } acl_mode_s;

   // Result delivered by the analog core after a conversion or a measurement.
   typedef struct packed {
      logic valid;
      logic [`ACL_COR_W-1:0] code;
   } acl_core_res_s;

   typedef enum logic [1:0] {ACL_ST_IDLE, ACL_ST_CAL, ACL_ST_ZERO, ACL_ST_CONV} acl_state_e;

endpackage : acl_pkg

`default_nettype wire

// ---- verification/acl_ctrl_properties.sv ----
/* Checker of the calibration and mode control block.
   Assumes it is bound to acl_ctrl_top and sees only its ports. */
`default_nettype none
`include "acl_consts.svh"
module acl_ctrl_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [31:0] reg_rdata,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_instruction_in,
   input wire logic serial_data_out,
   input wire logic meas_req,
   input wire logic [`ACL_COR_IDX_W-1:0] meas_idx,
   input wire acl_pkg::acl_core_res_s meas_res,
   input wire logic conv_start,
   input wire acl_pkg::acl_mode_s mode_out,
   input wire acl_pkg::acl_core_res_s conv_res,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // An idle control write starts measuring with the offset entry.
   property p_ctrl_start;
      reg_we && reg_addr == 4'h0 && |reg_wdata[1:0] && !busy |=> meas_req && meas_idx == 4'h0;
   endproperty
   a_ctrl_start: assert property (p_ctrl_start)
      else $error("control write did not start a measurement");
   // Each answered gain or linearity entry except entry 15 asks for the next one.
   property p_meas_step;
      meas_res.valid && busy && !meas_req && meas_idx != 4'h0 && meas_idx != 4'hF
         |=> meas_req && meas_idx == $past(meas_idx) + 4'h1;
   endproperty
   a_meas_step: assert property (p_meas_step)
      else $error("calibration skipped a correction entry");
   // Requests are single pulses.
   property p_pulses;
      meas_req || conv_start |=> !meas_req && !conv_start;
   endproperty
   a_pulses: assert property (p_pulses)
      else $error("request pulse longer than one cycle");
   // Running cycles never touch the stored settings.
   property p_mode_frozen;
      busy && $past(busy) |-> $stable(mode_out);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen)
      else $error("settings changed while busy");
   // Settings come out of reset at their defaults.
   property p_rst_mode;
      $fell(rst) |-> mode_out == 11'h014 && !busy;
   endproperty
   a_rst_mode: assert property (p_rst_mode)
      else $error("settings not at defaults after reset");
   // Read data are zero outside the answer cycle.
   property p_rdata_idle;
      !reg_re |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside the answer cycle");
   // The word length follows resolution, extension and the kept sign setting.
   property p_mode_read;
      reg_re && reg_addr == 4'h8 |=> reg_rdata[10:0] == $past(mode_out) && reg_rdata[15:11] ==
         ($past(mode_out.res8) ? 5'h08 : $past(mode_out.ext_len) ? 5'h10 : 5'h0C)
         + 5'($past(mode_out.sign_on));
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("mode read back wrong");
   // Status shows the running flag and the power state.
   property p_status;
      reg_re && reg_addr == 4'h4 |=> reg_rdata[3] == $past(busy)
         && reg_rdata[2] == $past(mode_out.power_down);
   endproperty
   a_status: assert property (p_status)
      else $error("status read back wrong");
endmodule : acl_ctrl_properties
bind acl_ctrl_top acl_ctrl_properties u_acl_ctrl_properties (.*);
`default_nettype wire

// ---- verification/acl_ctrl_top_bench.sv ----
/* Self-checking bench of the calibration and mode control block.
   Assumes the host model drives the link; a core stand-in lives here. */
`default_nettype none
module acl_ctrl_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] ins; logic [10:0] mode; logic [4:0] len;} acl_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [31:0] reg_rdata;
   wire logic sclk, cs_n, serial_instruction_in, serial_data_out;
   logic meas_req, conv_start, busy, in_conv;
   logic [3:0] meas_idx;
   acl_pkg::acl_core_res_s meas_res = '0, conv_res = '0;
   acl_pkg::acl_mode_s mode_out;
   int bad_count = 0, comparisons = 0, mcnt = 0, nreq = 0, core_dly = 7;
   logic [12:0] ofs_code = 13'h0005, raw_code = 13'h0064;
   logic [16:0] w;
   logic [4:0] len;
   acl_row_s rows [19] = '{{8'h00, 11'h014, 5'h0D}, {8'h9F, 11'h004, 5'h0C},
      {8'h00, 11'h004, 5'h0C}, {8'h0B, 11'h384, 5'h08}, {8'h8F, 11'h394, 5'h09},
      {8'h30, 11'h074, 5'h11}, {8'h4F, 11'h070, 5'h11}, {8'h6F, 11'h078, 5'h11},
      {8'h7F, 11'h07C, 5'h11}, {8'h5F, 11'h074, 5'h11}, {8'h3F, 11'h076, 5'h11},
      {8'h30, 11'h076, 5'h11}, {8'h2F, 11'h074, 5'h11}, {8'hAF, 11'h075, 5'h11},
      {8'h30, 11'h075, 5'h11}, {8'hBF, 11'h074, 5'h11},
      {8'h1F, 11'h074, 5'h11}, {8'h0F, 11'h074, 5'h11}, {8'h00, 11'h014, 5'h0D}};
   always #2.5 clk = ~clk;
   acl_ctrl_top u_acl_ctrl_top (.*);
   acl_host_model u_acl_host_model (.*);
   // Core stand-in; a long delay keeps the sequencer waiting.
   always @(posedge clk) begin
      meas_res <= '0;
      conv_res <= '0;
      if (meas_req || conv_start) begin
         mcnt <= core_dly;
         in_conv <= conv_start;
         nreq <= nreq + int'(meas_req);
      end else if (mcnt != 0) begin
         mcnt <= mcnt - 1;
         if (mcnt == 1 && in_conv) conv_res <= {1'b1, raw_code};
         if (mcnt == 1 && !in_conv) meas_res <= {1'b1, meas_idx == 4'h0 ? ofs_code : 13'h0000};
      end
   end
   task automatic end_sim();
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   // Strobes rise right after an edge and stay until the next task call.
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we <= we;
      reg_re <= ~we;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : bus
   task automatic idle();
      @(posedge clk);
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      #1;
   endtask : idle
   task automatic chk_reg(input string what, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      idle();
      check(what, exp, reg_rdata);
   endtask : chk_reg
   // Action lands a few cycles after the frame, so wait that out before polling.
   task automatic settle();
      int n;
      n = 0;
      repeat (6) @(posedge clk);
      #1;
      while (busy !== 1'b0) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 3000) begin
            bad_count++;
            $display("unexpected busy: expected 0, seen %b", busy);
            end_sim();
         end
      end
   endtask : settle
   initial begin
      u_acl_host_model.idle_clocks(3);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      u_acl_host_model.idle_clocks(3);
      chk_reg("status", 4'h4, 32'h0000_0000);
      chk_reg("mode", 4'h8, 32'h0000_6814);
      chk_reg("unmapped", 4'h2, 32'h0000_0000);
      bus(1'b1, 4'h8, 32'h0000_FFFF);
      idle();
      chk_reg("mode after write", 4'h8, 32'h0000_6814);
      // Calibration first, with a zero request right behind it that must be dropped.
      bus(1'b1, 4'h0, 32'h0000_0001);
      bus(1'b1, 4'h0, 32'h0000_0002);
      idle();
      settle();
      check("cal requests", 32'h0000_0010, nreq);
      chk_reg("cal status", 4'h4, 32'h0000_0010);
      u_acl_host_model.frame(8'h00, 5'h0D, w);
      settle();
      chk_reg("corrected", 4'hC, 32'h0000_005F);
      ofs_code = 13'h0009;
      core_dly = 1;
      nreq = 0;
      bus(1'b1, 4'h0, 32'h0000_0002);
      idle();
      settle();
      check("zero requests", 32'h0000_0001, nreq);
      u_acl_host_model.frame(8'h00, 5'h0D, w);
      settle();
      check("serial word", 32'h0000_005F, 32'(w));
      chk_reg("rezeroed", 4'hC, 32'h0000_005B);
      chk_reg("mode kept", 4'h8, 32'h0000_6814);
      len = 5'h0D;
      foreach (rows[i]) begin
         u_acl_host_model.frame(rows[i].ins, len, w);
         settle();
         check("mode_out", 32'(rows[i].mode), 32'(mode_out));
         chk_reg("word length", 4'h8, {16'h0000, rows[i].len, rows[i].mode});
         // Row 6 shifts out 91 as a 17-bit LSB-first word, so it arrives bit-reversed.
         if (i == 6) check("lsb word", 32'h0001_B400, 32'(w));
         len = rows[i].len;
      end
      end_sim();
   end
endmodule : acl_ctrl_top_bench
`default_nettype wire

// ---- verification/acl_host_model.sv ----
/* Host side of the serial link: link clock, frame select, data in and out.
   Assumes the bench calls its tasks one at a time. */
`default_nettype none
module acl_host_model (
   input wire logic serial_data_out,
   output var logic sclk,
   output var logic cs_n,
   output var logic serial_instruction_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // The link clock rests low outside frames; outside frames the host clocks it only in idle_clocks.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_instruction_in = 1'b0;
   end
   // Clock edges with the frame select high, needed around reset.
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
   endtask : idle_clocks
   // One frame; data change while the clock is low, out data taken after each rise.
   task automatic frame(input logic [7:0] ins, input logic [4:0] len, output logic [16:0] w);
      w = 17'h0_0000;
      cs_n = 1'b0;
      for (int i = 0; i < len; i++) begin
         serial_instruction_in = (i < 8) ? ins[i] : ~serial_instruction_in;
         #32 sclk = 1'b1;
         #16 w = {w[15:0], serial_data_out};
         #16 sclk = 1'b0;
      end
      #16 cs_n = 1'b1;
      serial_instruction_in = ~serial_instruction_in; // Released line must not hold its level.
   endtask : frame
endmodule : acl_host_model
`default_nettype wire

// ---- verilog/acl_corr_mem.sv ----
/*
 * Correction memory: offset, gain and linearity correction words.
 * Assumes one write port from the calibration sequencer in the same clock.
 */
`default_nettype none
`include "acl_consts.svh"

module acl_corr_mem (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [`ACL_COR_IDX_W-1:0] wr_idx,
   input wire logic [`ACL_COR_W-1:0] wr_data,
   input wire logic [`ACL_COR_IDX_W-1:0] lin_idx,
   output logic [`ACL_COR_W-1:0] offset_cor,
   output logic [`ACL_COR_W-1:0] gain_cor,
   output logic [`ACL_COR_W-1:0] lin_cor
);

   logic [`ACL_COR_W-1:0] mem_reg [`ACL_COR_N];
   logic [`ACL_COR_W-1:0] mem_next [`ACL_COR_N];

   // Only the addressed entry changes; zero-offset cycles touch entry 0 alone.
   always_comb begin
      for (int i = 0; i < `ACL_COR_N; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (wr_en) begin
         mem_next[wr_idx] = wr_data;
      end
   end

   // Cleared at reset so an uncalibrated part converts without correction.
   always_ff @(posedge clk) begin
      for (int i = 0; i < `ACL_COR_N; i++) begin
         mem_reg[i] <= rst ? '0 : mem_next[i];
      end
   end

   // Read ports used by every conversion.
   assign offset_cor = mem_reg[`ACL_COR_OFS];
   assign gain_cor = mem_reg[`ACL_COR_GAIN];
   assign lin_cor = mem_reg[lin_idx];

endmodule : acl_corr_mem

`default_nettype wire

// ---- verilog/acl_ctrl_top.sv ----
/*
 * Calibration and mode control of a self-calibrating converter with a
 * serial instruction link, correction memory and a plain register port.
 * Assumes the host clocks the link on sclk, holds cs_n low for a frame and
 * changes serial_instruction_in while sclk is low; the analog core answers
 * requests in the clk domain.
 */
// Contract
// - Full calibration measures offset, gain and linearity corrections, stores them and applies offset, gain and one of entries 2..9 to every conversion.
// - The offset-zeroing instruction runs a cycle that refreshes only the offset correction.
// - Mode state resets to no auto calibration, no auto zero, 10-period acquisition, 12 bits, sign on, powered up, MSB first, user mode.
// - Calibration, zeroing, power-up and power-down instructions leave channel, resolution, acquisition, sign and format alone.
// - An all-zero instruction selects channel zero positive, channel one negative, 12 bits and an MSB-first word of 13 bits with sign on, 12 with sign off.
// - The sign setting persists across frames, so the word length follows the last programmed sign setting.
// - The output word length is one of 8, 9, 12, 13, 16 or 17, agreed by device and host.
`default_nettype none
`include "acl_consts.svh"

module acl_ctrl_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_instruction_in,
   output logic serial_data_out,
   output logic meas_req,
   output logic [`ACL_COR_IDX_W-1:0] meas_idx,
   input wire acl_pkg::acl_core_res_s meas_res,
   output logic conv_start,
   output acl_pkg::acl_mode_s mode_out,
   input wire acl_pkg::acl_core_res_s conv_res,
   output logic busy
);

   // Word length from the stored mode: base width plus the sign bit if kept.
   function automatic logic [`ACL_LEN_W-1:0] word_len(input acl_pkg::acl_mode_s m);
      logic [`ACL_LEN_W-1:0] base;
      base = m.res8 ? `ACL_BASE_8 : (m.ext_len ? `ACL_BASE_16 : `ACL_BASE_12);
      return base + {4'h0, m.sign_on};
   endfunction : word_len

   // Shapes a corrected code into a left-aligned word ready to shift out.
   function automatic logic [`ACL_OUT_W-1:0] fmt_word(input logic [`ACL_COR_W-1:0] code,
                                                      input acl_pkg::acl_mode_s m);
      logic [`ACL_OUT_W-1:0] val;
      logic [`ACL_OUT_W-1:0] rev;
      logic [`ACL_LEN_W-1:0] len;
      len = word_len(m);
      if (m.res8) begin
         val = {{8{code[12]}}, code[12:4]};
      end else if (m.ext_len) begin
         val = {{4{code[12]}}, code};
      end else begin
         val = {4'h0, code};
      end
      if (!m.sign_on) begin
         val[len] = 1'b0; // The sign slot above the field is dropped.
      end
      rev = '0;
      for (int i = 0; i < `ACL_OUT_W; i++) begin
         if (i < int'(len)) begin
            rev[int'(len) - 1 - i] = val[i];
         end
      end
      if (m.lsb_first) begin
         val = rev;
      end
      return val << (5'(`ACL_OUT_W) - len);
   endfunction : fmt_word

   // Link domain: reset and settings brought over on sclk.
   logic lrst_s1_reg, lrst_s2_reg;
   logic [`ACL_LEN_W-1:0] len_s1_reg, len_s2_reg;
   logic [`ACL_OUT_W-1:0] out_word_reg;
   acl_pkg::acl_mode_s mode_reg, mode_next;

   // The length only changes between frames and is first needed at the third
   // edge of a frame, so a two-stage capture on sclk is enough for it.
   always_ff @(posedge sclk) begin
      lrst_s1_reg <= rst;
      lrst_s2_reg <= lrst_s1_reg;
      len_s1_reg <= word_len(mode_reg);
      len_s2_reg <= len_s1_reg;
   end

   logic [`ACL_INSTR_W-1:0] sh_in_reg, sh_in_next;
   logic [`ACL_INSTR_W-1:0] instr_reg, instr_next;
   logic [`ACL_OUT_W-1:0] sh_out_reg, sh_out_next;
   logic [`ACL_LEN_W-1:0] cnt_reg, cnt_next;
   logic sdo_reg, sdo_next;
   logic done_tog_reg, done_tog_next;

   // Frame engine on sclk. A count at the word length means the last frame
   // ended, since sclk may stand still while cs_n is high.
   always_comb begin
      logic start;
      start = 1'b0;
      sh_in_next = sh_in_reg;
      instr_next = instr_reg;
      sh_out_next = sh_out_reg;
      cnt_next = cnt_reg;
      sdo_next = sdo_reg;
      done_tog_next = done_tog_reg;
      if (cs_n) begin
         cnt_next = '0;
      end else begin
         start = (cnt_reg == '0) || (cnt_reg >= len_s2_reg);
         if (start || (cnt_reg < len_s2_reg)) begin
            if (start) begin
               // The result word stands still between frames; sclk stops
               // there, so a synchroniser would still hold the older word.
               sdo_next = out_word_reg[`ACL_OUT_W-1];
               sh_out_next = out_word_reg << 1;
               cnt_next = 5'h01;
            end else begin
               sdo_next = sh_out_reg[`ACL_OUT_W-1];
               sh_out_next = sh_out_reg << 1;
               cnt_next = cnt_reg + 5'h01;
            end
            if (start || (cnt_reg < 5'(`ACL_INSTR_W))) begin
               sh_in_next = {serial_instruction_in, sh_in_reg[`ACL_INSTR_W-1:1]};
            end
            if (cnt_next == 5'(`ACL_INSTR_W)) begin
               instr_next = {serial_instruction_in, sh_in_reg[`ACL_INSTR_W-1:1]};
            end
            if (cnt_next == len_s2_reg) begin
               done_tog_next = ~done_tog_reg;
            end
         end
      end
   end

   always_ff @(posedge sclk) begin
      if (lrst_s2_reg) begin
         sh_in_reg <= '0;
         instr_reg <= '0;
         sh_out_reg <= '0;
         cnt_reg <= '0;
         sdo_reg <= 1'b0;
         done_tog_reg <= 1'b0;
      end else begin
         sh_in_reg <= sh_in_next;
         instr_reg <= instr_next;
         sh_out_reg <= sh_out_next;
         cnt_reg <= cnt_next;
         sdo_reg <= sdo_next;
         done_tog_reg <= done_tog_next;
      end
   end

   assign serial_data_out = sdo_reg;

   // Frame-done toggle crossing into clk; stage three only feeds the edge.
   logic tg_s1_reg, tg_s2_reg, tg_s3_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         tg_s1_reg <= 1'b0;
         tg_s2_reg <= 1'b0;
         tg_s3_reg <= 1'b0;
      end else begin
         tg_s1_reg <= done_tog_reg;
         tg_s2_reg <= tg_s1_reg;
         tg_s3_reg <= tg_s2_reg;
      end
   end

   logic frame_done;
   assign frame_done = tg_s2_reg ^ tg_s3_reg;

   // Control domain state.
   acl_pkg::acl_state_e state_reg, state_next;
   logic [`ACL_COR_IDX_W-1:0] idx_reg, idx_next;
   logic req_reg, req_next;
   logic conv_pend_reg, conv_pend_next;
   logic start_reg, start_next;
   logic cal_done_reg, cal_done_next;
   logic [`ACL_COR_W-1:0] result_reg, result_next;
   logic [`ACL_OUT_W-1:0] out_word_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wr_en;
   logic [`ACL_COR_W-1:0] offset_cor, gain_cor, lin_cor;
   logic [`ACL_COR_IDX_W-1:0] lin_idx;

   // Linearity segment from the top three bits of the raw magnitude.
   assign lin_idx = `ACL_COR_LIN0 + {1'b0, conv_res.code[11:9]};

   acl_corr_mem u_mem (
      .clk(clk),
      .rst(rst),
      .wr_en(wr_en),
      .wr_idx(idx_reg),
      .wr_data(meas_res.code),
      .lin_idx(lin_idx),
      .offset_cor(offset_cor),
      .gain_cor(gain_cor),
      .lin_cor(lin_cor)
   );

   // Stored corrections applied to the raw code, saturated to 13 bits.
   logic signed [31:0] corr_sum;
   always_comb begin
      logic signed [31:0] raw;
      raw = 32'(signed'(conv_res.code));
      corr_sum = raw - 32'(signed'(offset_cor)) + 32'(signed'(lin_cor))
                 + ((raw * 32'(signed'(gain_cor))) >>> `ACL_GAIN_SHIFT);
   end

   logic [`ACL_COR_W-1:0] corr_sat;
   assign corr_sat = (corr_sum > 32'sd4095) ? 13'h0FFF :
                     (corr_sum < -32'sd4096) ? 13'h1000 : corr_sum[`ACL_COR_W-1:0];

   assign wr_en = (state_reg != acl_pkg::ACL_ST_IDLE) && (state_reg != acl_pkg::ACL_ST_CONV)
                  && meas_res.valid && !req_reg;

   // Sequencer: instruction decode, calibration, zeroing and conversion.
   always_comb begin
      logic [`ACL_INSTR_W-1:0] ins;
      logic sw_cal;
      logic sw_zero;
      ins = instr_reg;
      sw_cal = reg_we && (reg_addr == `ACL_OFS_CTRL) && reg_wdata[`ACL_CTRL_CAL_BIT];
      sw_zero = reg_we && (reg_addr == `ACL_OFS_CTRL) && reg_wdata[`ACL_CTRL_ZERO_BIT];
      state_next = state_reg;
      mode_next = mode_reg;
      idx_next = idx_reg;
      req_next = 1'b0;
      conv_pend_next = conv_pend_reg;
      start_next = 1'b0;
      cal_done_next = cal_done_reg;
      result_next = result_reg;
      out_word_next = out_word_reg;
      unique case (state_reg)
         acl_pkg::ACL_ST_IDLE: begin
            if (sw_cal) begin
               state_next = acl_pkg::ACL_ST_CAL;
               idx_next = `ACL_COR_OFS;
               req_next = 1'b1;
            end else if (sw_zero) begin
               state_next = acl_pkg::ACL_ST_ZERO;
               idx_next = `ACL_COR_OFS;
               req_next = 1'b1;
            end else if (frame_done && (ins[3:0] == `ACL_CMD_MARK)) begin
               // Commands touch only their own field of the mode state.
               unique case (ins[7:4])
                  `ACL_CMD_CAL: begin
                     state_next = acl_pkg::ACL_ST_CAL;
                     idx_next = `ACL_COR_OFS;
                     req_next = 1'b1;
                  end
                  `ACL_CMD_ZERO: begin
                     state_next = acl_pkg::ACL_ST_ZERO;
                     idx_next = `ACL_COR_OFS;
                     req_next = 1'b1;
                  end
                  `ACL_CMD_PWR_UP: mode_next.power_down = 1'b0;
                  `ACL_CMD_PWR_DOWN: mode_next.power_down = 1'b1;
                  `ACL_CMD_ACQ6: mode_next.acq_sel = `ACL_ACQ_6;
                  `ACL_CMD_ACQ10: mode_next.acq_sel = `ACL_ACQ_10;
                  `ACL_CMD_ACQ18: mode_next.acq_sel = `ACL_ACQ_18;
                  `ACL_CMD_ACQ34: mode_next.acq_sel = `ACL_ACQ_34;
                  `ACL_CMD_SIGN_ON: mode_next.sign_on = 1'b1;
                  `ACL_CMD_SIGN_OFF: mode_next.sign_on = 1'b0;
                  `ACL_CMD_AZ_ON: mode_next.auto_zero = 1'b1;
                  `ACL_CMD_AZ_OFF: mode_next.auto_zero = 1'b0;
                  default: ; // Unused command codes are ignored.
               endcase
            end else if (frame_done) begin
               // Conversion instruction; all zeros gives channel 0/1, 12 bits, MSB first.
               mode_next.chan = ins[`ACL_F_CHAN_LSB +: 3];
               mode_next.res8 = ins[`ACL_F_RES8];
               mode_next.lsb_first = ins[`ACL_F_LSBF];
               mode_next.ext_len = ins[`ACL_F_EXT];
               if (!mode_reg.power_down) begin
                  if (mode_reg.auto_zero) begin
                     state_next = acl_pkg::ACL_ST_ZERO;
                     idx_next = `ACL_COR_OFS;
                     req_next = 1'b1;
                     conv_pend_next = 1'b1;
                  end else begin
                     state_next = acl_pkg::ACL_ST_CONV;
                     start_next = 1'b1;
                  end
               end
            end
         end
         acl_pkg::ACL_ST_CAL: begin
            // Walks offset, gain and every linearity segment in turn.
            if (wr_en) begin
               if (idx_reg == `ACL_COR_LAST) begin
                  state_next = acl_pkg::ACL_ST_IDLE;
                  cal_done_next = 1'b1;
               end else begin
                  idx_next = idx_reg + 4'h1;
                  req_next = 1'b1;
               end
            end
         end
         acl_pkg::ACL_ST_ZERO: begin
            if (wr_en) begin
               if (conv_pend_reg) begin
                  state_next = acl_pkg::ACL_ST_CONV;
                  start_next = 1'b1;
                  conv_pend_next = 1'b0;
               end else begin
                  state_next = acl_pkg::ACL_ST_IDLE;
               end
            end
         end
         acl_pkg::ACL_ST_CONV: begin
            if (conv_res.valid && !start_reg) begin
               result_next = corr_sat;
               out_word_next = fmt_word(corr_sat, mode_reg);
               state_next = acl_pkg::ACL_ST_IDLE;
            end
         end
      endcase
   end

   // Register reads answer one cycle after the strobe; unmapped reads give zero.
   always_comb begin
      rdata_next = '0;
      if (reg_re) begin
         unique case (reg_addr)
            `ACL_OFS_STATUS: rdata_next = {27'h000_0000, cal_done_reg, busy,
                                           mode_reg.power_down, state_reg};
            // Word length sits in bits 15:11, directly above the mode bits.
            `ACL_OFS_MODE: rdata_next = {16'h0000, word_len(mode_reg), mode_reg};
            `ACL_OFS_RESULT: rdata_next = {19'h0_0000, result_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   // Power-up mode state follows the documented defaults.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= acl_pkg::ACL_ST_IDLE;
         mode_reg <= '{chan: 3'h0, res8: 1'b0, lsb_first: 1'b0, ext_len: 1'b0,
                       sign_on: 1'b1, acq_sel: `ACL_ACQ_10, power_down: 1'b0,
                       auto_zero: 1'b0};
         idx_reg <= '0;
         req_reg <= 1'b0;
         conv_pend_reg <= 1'b0;
         start_reg <= 1'b0;
         cal_done_reg <= 1'b0;
         result_reg <= '0;
         out_word_reg <= '0;
         rdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         idx_reg <= idx_next;
         req_reg <= req_next;
         conv_pend_reg <= conv_pend_next;
         start_reg <= start_next;
         cal_done_reg <= cal_done_next;
         result_reg <= result_next;
         out_word_reg <= out_word_next;
         rdata_reg <= rdata_next;
      end
   end

   // Outputs to the analog core and the register port.
   assign meas_req = req_reg;
   assign meas_idx = idx_reg;
   assign conv_start = start_reg;
   assign mode_out = mode_reg;
   assign busy = (state_reg != acl_pkg::ACL_ST_IDLE);
   assign reg_rdata = rdata_reg;

endmodule : acl_ctrl_top

`default_nettype wire
